// ---- src/acb_compare.sv ----
`timescale 1ns/1ps
`default_nettype none
module acb_compare
  import acb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sample and thresholds
  input wire logic sample,
  input wire logic [11:0] value,
  input wire logic [11:0] high,
  input wire logic [11:0] low,
  input wire logic is_signed,
  // Mode
  input wire logic window_sel,
  input wire logic [1:0] hyst_sel,
  // Result
  output logic hi_state,
  output logic lo_state,
  output logic hi_event,
  output logic lo_event
);

  logic signed [13:0] v;
  logic signed [13:0] h;
  logic signed [13:0] l;
  logic signed [13:0] hy;

  // Temperature is two's complement, the rest straight binary
  assign v = is_signed ? {{2{value[11]}}, value} : {2'h0, value};
  assign h = is_signed ? {{2{high[11]}}, high} : {2'h0, high};
  assign l = is_signed ? {{2{low[11]}}, low} : {2'h0, low};
  assign hy = 14'(ACB_HYST_MIN_LSB << hyst_sel);

  assign hi_event = sample && (v > h);
  assign lo_event = sample && window_sel && (v < l);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_state <= 1'b0;
      lo_state <= 1'b0;
    end
    else if (sample && window_sel)
    begin
      // Band with hysteresis on both edges
      if (v > h)
        hi_state <= 1'b1;
      else if (v < h - hy)
        hi_state <= 1'b0;
      if (v < l)
        lo_state <= 1'b1;
      else if (v > l + hy)
        lo_state <= 1'b0;
    end
    else if (sample)
    begin
      // Set above high, held until below low
      if (v > h)
        hi_state <= 1'b1;
      else if (v < l)
        hi_state <= 1'b0;
      lo_state <= 1'b0;
    end
  end

  AST_HYS_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (sample && !window_sel && hi_state && !(v < l)) |=> hi_state)
    else $error("hysteresis alarm released above low threshold");

endmodule : acb_compare
`default_nettype wire

// ---- src/acb_pkg.sv ----
package acb_pkg;

  // ----------------------------------------------------------------
  // Host commands
  // ----------------------------------------------------------------
  localparam logic [7:0] ACB_CMD_FLAG_READ = 8'hf8;
  localparam logic [7:0] ACB_CMD_RESULT_READ = 8'h80;

  // ----------------------------------------------------------------
  // Quantities and formats
  // ----------------------------------------------------------------
  localparam int ACB_NUM_QTY = 7;
  localparam int ACB_DATA_W = 12;
  localparam int ACB_WORD_W = 16;
  localparam int ACB_FLAG_W = 12;
  localparam logic [3:0] ACB_TAG_FLAGS = 4'hf;
  localparam logic [11:0] ACB_THR_HIGH_RESET = 12'hfff;
  localparam logic [11:0] ACB_THR_LOW_RESET = 12'h000;
  localparam int ACB_HYST_MIN_LSB = 8;
  // Quantity kinds; flag bit = channel*6 + kind*2 (+1 for high)
  localparam int ACB_KIND_TEMP = 0;
  localparam int ACB_KIND_SENSE = 1;
  localparam int ACB_KIND_GATE = 2;
  localparam int ACB_QTY_INT_TEMP = 6;
  localparam int ACB_FLAGS_PER_CH = 6;

  // ----------------------------------------------------------------
  // Hardware alarm configuration word
  // ----------------------------------------------------------------
  localparam logic [15:0] ACB_CFG_RESET = 16'h0000;
  localparam int ACB_CFG_ACTIVE_LOW = 0;
  localparam int ACB_CFG_COMPARATOR = 1;
  localparam int ACB_CFG_CLAMP_LSB = 2;
  localparam int ACB_CFG_OPEN_DRAIN = 6;
  localparam int ACB_CFG_HYST_LSB = 7;
  localparam logic [1:0] ACB_CLAMP_RES = 2'h0;
  localparam logic [1:0] ACB_CLAMP_OFF = 2'h1;
  localparam logic [1:0] ACB_CLAMP_AUTO = 2'h2;
  localparam logic [1:0] ACB_CLAMP_LATCH = 2'h3;

  typedef enum logic {ACB_SER_IDLE, ACB_SER_SHIFT} acb_ser_state_type;

endpackage : acb_pkg

// ---- src/acb_serial_out.sv ----
`timescale 1ns/1ps
`default_nettype none
module acb_serial_out
  import acb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Load side
  input wire logic load,
  input wire logic [15:0] word,
  // Link side, already synchronised
  input wire logic i2c_mode,
  input wire logic ser_clk,
  output logic data_out,
  output logic active
);

  acb_ser_state_type state;
  logic ser_clk_prev;
  logic [15:0] shreg;
  logic [3:0] remaining;
  logic shift_edge;

  // Falling edge for SPI, rising edge for I2C
  assign shift_edge = i2c_mode ? (ser_clk && !ser_clk_prev) : (!ser_clk && ser_clk_prev);
  assign active = (state == ACB_SER_SHIFT);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ser_clk_prev <= 1'b0;
    else
      ser_clk_prev <= ser_clk;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ACB_SER_IDLE;
      shreg <= 16'h0000;
      remaining <= 4'h0;
      data_out <= 1'b1;
    end
    else if (load)
    begin
      // Two bytes, MSB first
      state <= ACB_SER_SHIFT;
      data_out <= word[15];
      shreg <= {word[14:0], 1'b1};
      remaining <= 4'hf;
    end
    else
    begin
      case (state)
        ACB_SER_SHIFT:
          if (shift_edge)
          begin
            data_out <= shreg[15];
            shreg <= {shreg[14:0], 1'b1};
            remaining <= remaining - 4'h1;
            if (remaining == 4'h0)
              state <= ACB_SER_IDLE;
          end
        default:
          state <= ACB_SER_IDLE;
      endcase
    end
  end

  AST_SER_MSB: assert property (@(posedge clk) disable iff (!rst_n)
    load |=> (data_out == $past(word[15])) && active)
    else $error("first serial bit is not the MSB");

  AST_SER_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
    (!load && !shift_edge) |=> $stable(data_out))
    else $error("serial bit changed off its clock edge");

endmodule : acb_serial_out
`default_nettype wire

// ---- src/acb_supervisor.sv ----
// Overview of operation
// - Results leave as two bytes, MSB first
// - SPI shifts on falling, I2C on rising
// - Binary, temperature two's complement 0.125 C
// - Busy for conversion, init, calc, calibration
// - Continuous conversion never raises busy
// - Reads allowed while busy, give older result
// - Every conversion compared with both thresholds
// - Window mode alarms outside the band
// - Window hysteresis selectable 8 to 64 LSB
// - Hysteresis mode: above high, until below low
// - Interrupt mode holds until flag read
// - Comparator mode follows internal alarm state
// - Thresholds reset high ones, low zeros
// - Alarm pin polarity and drive configurable
// - Clamp code two bits per channel
// - Code 00 clamps through series resistor
// - Code 01 never clamps, alarms still work
// - Code 10 clamps while alarm present
// - Gate alarm under code 10 latches clamp
// - Code 11 latches until code 11 or 01 is written
// - Flag read command F8h clears all flags
`timescale 1ns/1ps
`default_nettype none
module acb_supervisor
  import acb_pkg::*;
#(
  parameter int NUM_QTY = ACB_NUM_QTY
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Host command, already decoded from the serial link
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_BYTE,
  // Configuration writes
  input wire logic CFG_WR,
  input wire logic [15:0] CFG_DATA,
  input wire logic THR_WR,
  input wire logic [2:0] THR_QTY,
  input wire logic THR_IS_HIGH,
  input wire logic [11:0] THR_DATA,
  input wire logic [1:0] TEMP_WINDOW_SELECT,
  input wire logic [1:0] SENSE_WINDOW_SELECT,
  input wire logic [1:0] GATE_WINDOW_SELECT,
  // Conversion results
  input wire logic CONV_VALID,
  input wire logic [2:0] CONV_QTY,
  input wire logic [11:0] CONV_DATA,
  // Busy causes
  input wire logic CONTINUOUS_CONVERSION_BIT,
  input wire logic CONV_ACTIVE,
  input wire logic CORE_INIT,
  input wire logic GATE_CODE_CALCULATION,
  input wire logic CORE_OTHER,
  input wire logic SELF_CAL,
  // Serial link pins
  input wire logic SER_CLK,
  input wire logic I2C_SELECT,
  output logic SER_DATA,
  output logic SER_DATA_OE,
  // Status and alarm pins
  output logic BUSY,
  output logic ALARM_OUT,
  output logic ALARM_OE,
  // Gate clamp controls, one bit per channel
  output logic [1:0] CLAMP_VOLTAGE_INPUT,
  output logic [1:0] CLAMP_SERIES_RES
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n_s;
  logic ser_clk_meta;
  logic ser_clk_s;
  logic i2c_meta;
  logic i2c_s;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta <= 1'b0;
      rst_n_s <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n_s <= rst_meta;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      ser_clk_meta <= 1'b0;
      ser_clk_s <= 1'b0;
      i2c_meta <= 1'b0;
      i2c_s <= 1'b0;
    end
    else
    begin
      ser_clk_meta <= SER_CLK;
      ser_clk_s <= ser_clk_meta;
      i2c_meta <= I2C_SELECT;
      i2c_s <= i2c_meta;
    end
  end

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  logic [15:0] cfg;
  logic comparator_mode;
  logic active_low;
  logic open_drain;
  logic [1:0] hyst_sel;

  // Power-up default: active high, interrupt mode, clamp code 00
  always_ff @(posedge CLK or negedge rst_n_s)
  begin
    if (!rst_n_s)
      cfg <= ACB_CFG_RESET;
    else if (CFG_WR)
      cfg <= CFG_DATA;
  end

  assign comparator_mode = cfg[ACB_CFG_COMPARATOR];
  assign active_low = cfg[ACB_CFG_ACTIVE_LOW];
  assign open_drain = cfg[ACB_CFG_OPEN_DRAIN];
  assign hyst_sel = cfg[ACB_CFG_HYST_LSB +: 2];

  // ----------------------------------------------------------------
  // Thresholds and comparators, one per quantity
  // ----------------------------------------------------------------
  logic [11:0] thr_high [NUM_QTY];
  logic [11:0] thr_low [NUM_QTY];
  logic [NUM_QTY-1:0] hi_state;
  logic [NUM_QTY-1:0] lo_state;
  logic [NUM_QTY-1:0] hi_event;
  logic [NUM_QTY-1:0] lo_event;

  genvar q;
  generate
    for (q = 0; q < NUM_QTY; q++)
    begin : g_qty
      localparam int KIND = (q == ACB_QTY_INT_TEMP) ? ACB_KIND_TEMP : q % 3;
      localparam int CH = (q < 3) ? 0 : 1;
      logic win;

      assign win = (KIND == ACB_KIND_TEMP) ? TEMP_WINDOW_SELECT[CH] :
                   (KIND == ACB_KIND_SENSE) ? SENSE_WINDOW_SELECT[CH] :
                   GATE_WINDOW_SELECT[CH];

      always_ff @(posedge CLK or negedge rst_n_s)
      begin
        if (!rst_n_s)
        begin
          thr_high[q] <= ACB_THR_HIGH_RESET;
          thr_low[q] <= ACB_THR_LOW_RESET;
        end
        else if (THR_WR && THR_QTY == 3'(q))
        begin
          if (THR_IS_HIGH)
            thr_high[q] <= THR_DATA;
          else
            thr_low[q] <= THR_DATA;
        end
      end

      acb_compare u_cmp (
        .clk(CLK),
        .rst_n(rst_n_s),
        .sample(CONV_VALID && CONV_QTY == 3'(q)),
        .value(CONV_DATA),
        .high(thr_high[q]),
        .low(thr_low[q]),
        .is_signed(KIND == ACB_KIND_TEMP),
        .window_sel(win),
        .hyst_sel(hyst_sel),
        .hi_state(hi_state[q]),
        .lo_state(lo_state[q]),
        .hi_event(hi_event[q]),
        .lo_event(lo_event[q])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Alarm flags
  // ----------------------------------------------------------------
  logic [11:0] flags;
  logic [11:0] flag_set;
  logic flag_read;
  logic result_read;

  assign flag_read = CMD_VALID && CMD_BYTE == ACB_CMD_FLAG_READ;
  assign result_read = CMD_VALID && CMD_BYTE == ACB_CMD_RESULT_READ;

  // Internal temperature shares channel 2 temperature flags
  always_comb
  begin
    flag_set = 12'h000;
    for (int i = 0; i < NUM_QTY; i++)
    begin
      int base;
      base = ((i < 3) ? 0 : ACB_FLAGS_PER_CH)
             + 2 * ((i == ACB_QTY_INT_TEMP) ? ACB_KIND_TEMP : i % 3);
      flag_set[base] = flag_set[base] | lo_event[i];
      flag_set[base + 1] = flag_set[base + 1] | hi_event[i];
    end
  end

  // A new breach on the read cycle survives the clear
  always_ff @(posedge CLK or negedge rst_n_s)
  begin
    if (!rst_n_s)
      flags <= 12'h000;
    else if (flag_read)
      flags <= flag_set;
    else
      flags <= flags | flag_set;
  end

  // ----------------------------------------------------------------
  // Alarm output
  // ----------------------------------------------------------------
  logic any_alarm;
  logic alarm_pend;
  logic alarm_act;
  logic alarm_level;

  assign any_alarm = |{hi_state, lo_state};

  always_ff @(posedge CLK or negedge rst_n_s)
  begin
    if (!rst_n_s)
      alarm_pend <= 1'b0;
    else if (|flag_set)
      alarm_pend <= 1'b1;
    else if (flag_read)
      alarm_pend <= 1'b0;
  end

  assign alarm_act = comparator_mode ? any_alarm : alarm_pend;
  assign alarm_level = alarm_act ^ active_low;

  // Open drain only pulls low; the high level comes from the pull-up
  always_ff @(posedge CLK or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      ALARM_OUT <= 1'b0;
      ALARM_OE <= 1'b1;
    end
    else
    begin
      ALARM_OUT <= alarm_level;
      ALARM_OE <= !open_drain || !alarm_level;
    end
  end

  // ----------------------------------------------------------------
  // Gate clamping per channel
  // ----------------------------------------------------------------
  logic [1:0] clamp_latch;

  genvar c;
  generate
    for (c = 0; c < 2; c++)
    begin : g_clamp
      localparam int BASE = c * 3;
      logic [1:0] code;
      logic [1:0] new_code;
      logic ch_alarm;
      logic gate_alarm;

      assign code = cfg[ACB_CFG_CLAMP_LSB + 2 * c +: 2];
      assign new_code = CFG_DATA[ACB_CFG_CLAMP_LSB + 2 * c +: 2];
      assign gate_alarm = hi_state[BASE + ACB_KIND_GATE] || lo_state[BASE + ACB_KIND_GATE];
      if (c == 0)
      begin : g_ch1
        assign ch_alarm = |{hi_state[2:0], lo_state[2:0]};
      end
      else
      begin : g_ch2
        assign ch_alarm = |{hi_state[NUM_QTY-1:3], lo_state[NUM_QTY-1:3]};
      end

      always_ff @(posedge CLK or negedge rst_n_s)
      begin
        if (!rst_n_s)
          clamp_latch[c] <= 1'b0;
        else if ((code == ACB_CLAMP_LATCH && ch_alarm)
                 || (code == ACB_CLAMP_AUTO && gate_alarm))
          clamp_latch[c] <= 1'b1;
        else if (CFG_WR && (new_code == ACB_CLAMP_LATCH || new_code == ACB_CLAMP_OFF))
          clamp_latch[c] <= 1'b0;
      end

      always_ff @(posedge CLK or negedge rst_n_s)
      begin
        if (!rst_n_s)
        begin
          CLAMP_VOLTAGE_INPUT[c] <= 1'b0;
          CLAMP_SERIES_RES[c] <= 1'b1;
        end
        else
        begin
          case (code)
            ACB_CLAMP_AUTO: CLAMP_VOLTAGE_INPUT[c] <= ch_alarm || clamp_latch[c];
            ACB_CLAMP_LATCH: CLAMP_VOLTAGE_INPUT[c] <= clamp_latch[c];
            default: CLAMP_VOLTAGE_INPUT[c] <= 1'b0;
          endcase
          CLAMP_SERIES_RES[c] <= (code == ACB_CLAMP_RES);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Busy and result buffer
  // ----------------------------------------------------------------
  logic [15:0] last_result;
  logic [15:0] load_word;
  logic ser_active;

  always_ff @(posedge CLK or negedge rst_n_s)
  begin
    if (!rst_n_s)
      BUSY <= 1'b0;
    else
      BUSY <= (CONV_ACTIVE && !CONTINUOUS_CONVERSION_BIT)
              || CORE_INIT || GATE_CODE_CALCULATION || CORE_OTHER || SELF_CAL;
  end

  // Updated only at completion, so a read mid-conversion sees the older word
  always_ff @(posedge CLK or negedge rst_n_s)
  begin
    if (!rst_n_s)
      last_result <= {ACB_TAG_FLAGS, 12'h000};
    else if (CONV_VALID)
      last_result <= {1'b0, CONV_QTY, CONV_DATA};
  end

  assign load_word = flag_read ? {4'h0, flags} : last_result;

  acb_serial_out u_ser (
    .clk(CLK),
    .rst_n(rst_n_s),
    .load(flag_read || result_read),
    .word(load_word),
    .i2c_mode(i2c_s),
    .ser_clk(ser_clk_s),
    .data_out(SER_DATA),
    .active(ser_active)
  );

  // I2C drives SDA low only; SPI drives DOUT while shifting
  assign SER_DATA_OE = ser_active && (!i2c_s || !SER_DATA);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n_s);

  AST_BUSY_CONT: assert property ((CONTINUOUS_CONVERSION_BIT && CONV_ACTIVE
    && !CORE_INIT && !GATE_CODE_CALCULATION && !CORE_OTHER && !SELF_CAL) |=> !BUSY)
    else $error("continuous conversion raised busy");
  AST_BUSY_CAUSE: assert property ((CORE_INIT || SELF_CAL || GATE_CODE_CALCULATION) |=> BUSY)
    else $error("busy missing for core activity");
  AST_FLAG_CLEAR: assert property ((flag_read && flag_set == 12'h000) |=> flags == 12'h000)
    else $error("flag read did not clear flags");
  AST_INT_HOLD: assert property ((!comparator_mode && alarm_pend && !flag_read
    && !CFG_WR) |=> alarm_pend && ALARM_OUT == !active_low)
    else $error("interrupt alarm dropped before flag read");
  AST_CMP_FOLLOW: assert property ((comparator_mode && !CFG_WR && !any_alarm)
    |=> ALARM_OUT == active_low)
    else $error("comparator alarm asserted without breach");
  AST_THR_RESET: assert property ($rose(rst_n_s)
    |-> thr_high[0] == ACB_THR_HIGH_RESET && thr_low[0] == ACB_THR_LOW_RESET)
    else $error("threshold reset values wrong");
  AST_CODE_OFF: assert property ((cfg[3:2] == ACB_CLAMP_OFF && !CFG_WR)
    |=> !CLAMP_VOLTAGE_INPUT[0])
    else $error("clamp applied in disabled mode");
  AST_CODE_RES: assert property ((cfg[3:2] == ACB_CLAMP_RES && !CFG_WR)
    |=> CLAMP_SERIES_RES[0])
    else $error("series resistor clamp missing");
  AST_LATCH_HOLD: assert property ((cfg[3:2] == ACB_CLAMP_LATCH
    && clamp_latch[0] && !CFG_WR) |=> clamp_latch[0])
    else $error("latched clamp released without rewrite");
  AST_PUSH_PULL: assert property ((!open_drain && !CFG_WR) |=> ALARM_OE)
    else $error("push-pull alarm not driven");

  COV_INT_ALARM: cover property (!comparator_mode && alarm_pend ##[1:20] flag_read);
  COV_LATCH: cover property (clamp_latch[0] ##[1:50] !clamp_latch[0]);
  COV_BUSY: cover property (BUSY ##1 !BUSY);

endmodule : acb_supervisor
`default_nettype wire

// ---- tb/acb_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module acb_host_model
(
  // Link pins
  input wire logic i2c,
  output logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_data_oe
);
  logic last_bit = 1'b1;
  // Clock stands low between frames in both modes
  initial ser_clk = 1'b0;
  // -----------------------------------------------------------
  // One frame of sixteen bits, first bit first
  // -----------------------------------------------------------
  // Sample away from the shifting edge, which the device moves late
  task automatic read_frame(output logic [15:0] word);
    for (int i = 15; i >= 0; i--)
    begin
      if (i2c)
      begin
        #8;
        // Released SDA reads high through its pull-up
        word[i] = ser_data_oe ? ser_data : 1'b1;
        last_bit = word[i];
        #8 ser_clk = 1'b1;
        #16 ser_clk = 1'b0;
      end
      else
      begin
        #16 ser_clk = 1'b1;
        #8;
        word[i] = ser_data_oe ? ser_data : ~last_bit;
        last_bit = word[i];
        #8 ser_clk = 1'b0;
      end
    end
  endtask : read_frame
endmodule : acb_host_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import acb_pkg::*;
  logic CLK = 1'b0, RST_N = 1'b0, CMD_VALID = 1'b0, CFG_WR = 1'b0, THR_WR = 1'b0;
  logic THR_IS_HIGH = 1'b0, CONV_VALID = 1'b0, CONT = 1'b0, I2C_SELECT = 1'b0;
  logic [7:0] CMD_BYTE = 8'h00;
  logic [15:0] CFG_DATA = 16'h0000;
  logic [2:0] THR_QTY = 3'h0, CONV_QTY = 3'h0;
  logic [11:0] THR_DATA = 12'h000, CONV_DATA = 12'h000;
  logic [1:0] TWS = 2'h0, SWS = 2'h0, GWS = 2'h3;
  logic [4:0] cause = 5'h00;
  logic SER_CLK, SER_DATA, SER_DATA_OE, BUSY, ALARM_OUT, ALARM_OE;
  logic [1:0] CLAMP_VOLTAGE_INPUT, CLAMP_SERIES_RES;
  logic [15:0] w;
  int fails = 0, total_checks = 0, h;

  acb_supervisor dut (.CLK(CLK), .RST_N(RST_N), .CMD_VALID(CMD_VALID), .CMD_BYTE(CMD_BYTE),
    .CFG_WR(CFG_WR), .CFG_DATA(CFG_DATA), .THR_WR(THR_WR), .THR_QTY(THR_QTY),
    .THR_IS_HIGH(THR_IS_HIGH), .THR_DATA(THR_DATA), .TEMP_WINDOW_SELECT(TWS),
    .SENSE_WINDOW_SELECT(SWS), .GATE_WINDOW_SELECT(GWS), .CONV_VALID(CONV_VALID),
    .CONV_QTY(CONV_QTY), .CONV_DATA(CONV_DATA), .CONTINUOUS_CONVERSION_BIT(CONT),
    .CONV_ACTIVE(cause[0]), .CORE_INIT(cause[1]), .GATE_CODE_CALCULATION(cause[2]),
    .CORE_OTHER(cause[3]), .SELF_CAL(cause[4]), .SER_CLK(SER_CLK), .I2C_SELECT(I2C_SELECT),
    .SER_DATA(SER_DATA), .SER_DATA_OE(SER_DATA_OE), .BUSY(BUSY), .ALARM_OUT(ALARM_OUT),
    .ALARM_OE(ALARM_OE), .CLAMP_VOLTAGE_INPUT(CLAMP_VOLTAGE_INPUT),
    .CLAMP_SERIES_RES(CLAMP_SERIES_RES));
  acb_host_model host (.i2c(I2C_SELECT), .ser_clk(SER_CLK), .ser_data(SER_DATA),
    .ser_data_oe(SER_DATA_OE));

  initial forever #2 CLK = ~CLK;
  // -----------------------------------------------------------
  // Access tasks
  // -----------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask : chk
  task automatic conv(input logic [2:0] q, input logic [11:0] d);
    @(posedge CLK);
    CONV_VALID <= 1'b1;
    CONV_QTY <= q;
    CONV_DATA <= d;
    @(posedge CLK);
    CONV_VALID <= 1'b0;
    tick(2);
  endtask : conv
  task automatic cfg(input logic [15:0] d);
    @(posedge CLK);
    CFG_WR <= 1'b1;
    CFG_DATA <= d;
    @(posedge CLK);
    CFG_WR <= 1'b0;
    tick(2);
  endtask : cfg
  task automatic thr(input logic [2:0] q, input logic hi, input logic [11:0] d);
    @(posedge CLK);
    THR_WR <= 1'b1;
    THR_QTY <= q;
    THR_IS_HIGH <= hi;
    THR_DATA <= d;
    @(posedge CLK);
    THR_WR <= 1'b0;
    tick(2);
  endtask : thr
  // Link clock phase kept apart from the system clock
  task automatic rd(input logic [7:0] b, input logic [15:0] exp);
    @(posedge CLK);
    CMD_VALID <= 1'b1;
    CMD_BYTE <= b;
    @(posedge CLK);
    CMD_VALID <= 1'b0;
    #1.3;
    host.read_frame(w);
    chk("frame", exp, w);
    tick(8);
    chk("data_oe", 16'h0, 16'(SER_DATA_OE));
  endtask : rd
  task automatic pins(input logic al, input logic [1:0] cv, input logic [1:0] sr);
    chk("alarm", 16'(al), 16'(ALARM_OUT));
    chk("clamp", 16'(cv), 16'(CLAMP_VOLTAGE_INPUT));
    chk("series", 16'(sr), 16'(CLAMP_SERIES_RES));
  endtask : pins
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    #100000;
    fails++;
    tally_and_finish();
  end
  // -----------------------------------------------------------
  // Tests
  // -----------------------------------------------------------
  initial
  begin
    tick(2);
    RST_N = 1'b1;
    tick(4);
    chk("busy", 16'h0, 16'(BUSY));
    chk("alarm_oe", 16'h1, 16'(ALARM_OE));
    pins(1'b0, 2'b00, 2'b11);
    conv(3'd2, 12'hfff);
    conv(3'd5, 12'h000);
    rd(ACB_CMD_FLAG_READ, 16'h0000);
    rd(ACB_CMD_RESULT_READ, 16'h5000);
    I2C_SELECT <= 1'b1;
    tick(8);
    rd(ACB_CMD_RESULT_READ, 16'h5000);
    I2C_SELECT <= 1'b0;
    tick(8);
    for (int i = 0; i < 5; i++)
    begin
      cause <= 5'(1 << i);
      tick(3);
      chk("busy", 16'h1, 16'(BUSY));
      cause <= 5'h00;
      tick(3);
      chk("busy", 16'h0, 16'(BUSY));
    end
    CONT <= 1'b1;
    cause <= 5'h01;
    tick(3);
    chk("busy", 16'h0, 16'(BUSY));
    cause <= 5'h11;
    tick(3);
    chk("busy", 16'h1, 16'(BUSY));
    CONT <= 1'b0;
    cause <= 5'h01;
    tick(3);
    rd(ACB_CMD_RESULT_READ, 16'h5000);
    conv(3'd4, 12'h123);
    cause <= 5'h00;
    tick(3);
    // Next conversion only once busy has dropped
    chk("busy", 16'h0, 16'(BUSY));
    rd(ACB_CMD_RESULT_READ, 16'h4123);
    TWS <= 2'b01;
    thr(3'd0, 1'b1, 12'h010);
    thr(3'd0, 1'b0, 12'hff0);
    conv(3'd0, 12'hf00);
    rd(ACB_CMD_FLAG_READ, 16'h0001);
    conv(3'd0, 12'h000);
    rd(ACB_CMD_FLAG_READ, 16'h0000);
    cfg(16'h0016);
    thr(3'd1, 1'b1, 12'h200);
    thr(3'd1, 1'b0, 12'h100);
    conv(3'd1, 12'h201);
    pins(1'b1, 2'b00, 2'b00);
    conv(3'd1, 12'h180);
    pins(1'b1, 2'b00, 2'b00);
    conv(3'd1, 12'h0ff);
    pins(1'b0, 2'b00, 2'b00);
    rd(ACB_CMD_FLAG_READ, 16'h0008);
    SWS <= 2'b10;
    thr(3'd4, 1'b1, 12'h400);
    for (int s = 0; s < 4; s++)
    begin
      h = 8 << s;
      cfg(16'h0016 | 16'(s << 7));
      conv(3'd4, 12'h401);
      chk("alarm", 16'h1, 16'(ALARM_OUT));
      conv(3'd4, 12'(12'h400 - h / 2));
      chk("alarm", 16'h1, 16'(ALARM_OUT));
      conv(3'd4, 12'(12'h400 - 2 * h));
      chk("alarm", 16'h0, 16'(ALARM_OUT));
    end
    rd(ACB_CMD_FLAG_READ, 16'h0200);
    cfg(16'h0014);
    conv(3'd1, 12'h201);
    conv(3'd1, 12'h0ff);
    chk("alarm", 16'h1, 16'(ALARM_OUT));
    rd(ACB_CMD_FLAG_READ, 16'h0008);
    chk("alarm", 16'h0, 16'(ALARM_OUT));
    cfg(16'h0055);
    chk("alarm_oe", 16'h0, 16'(ALARM_OE));
    conv(3'd1, 12'h201);
    chk("alarm", 16'h0, 16'(ALARM_OUT));
    chk("alarm_oe", 16'h1, 16'(ALARM_OE));
    conv(3'd1, 12'h0ff);
    rd(ACB_CMD_FLAG_READ, 16'h0008);
    chk("alarm_oe", 16'h0, 16'(ALARM_OE));
    cfg(16'h000a);
    pins(1'b0, 2'b00, 2'b10);
    conv(3'd1, 12'h201);
    pins(1'b1, 2'b01, 2'b10);
    conv(3'd1, 12'h0ff);
    pins(1'b0, 2'b00, 2'b10);
    thr(3'd2, 1'b1, 12'h300);
    conv(3'd2, 12'h301);
    conv(3'd2, 12'h100);
    pins(1'b0, 2'b01, 2'b10);
    cfg(16'h000e);
    pins(1'b0, 2'b00, 2'b10);
    conv(3'd1, 12'h201);
    conv(3'd1, 12'h0ff);
    pins(1'b0, 2'b01, 2'b10);
    cfg(16'h0006);
    pins(1'b0, 2'b00, 2'b10);
    cfg(16'h0002);
    conv(3'd4, 12'h401);
    pins(1'b1, 2'b00, 2'b11);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
